/* File: design/pin_change_defines.svh */
// Purpose: register offsets, field positions and reset values of the pin change block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef PIN_CHANGE_DEFINES_SVH
`define PIN_CHANGE_DEFINES_SVH

`define PCI_ADDR_W 4
`define PCI_OFF_RISE 4'h0
`define PCI_OFF_FALL 4'h4
`define PCI_OFF_FLAGS 4'h8
`define PCI_OFF_CTRL 4'hc
`define PCI_RST_RISE 8'h00
`define PCI_RST_FALL 8'h00
`define PCI_RST_FLAGS 8'h00
`define PCI_CTRL_MASTER_BIT 0
`define PCI_CTRL_SUMMARY_BIT 1
`define PCI_CTRL_SLEEP_BIT 2

`endif

/* File: design/pin_change_pkg.sv */
// Purpose: types shared by the pin change block
// Assumes: nothing
// Notes: apb request carried as one packed struct
package pin_change_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [3:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage : pin_change_pkg

/* File: design/port_pin_change_interrupt.sv */
// Purpose: per-pin edge detection with sticky change flags and wake request
// Assumes: pins synchronous to i_core_clk; apb slave with zero wait states
// Notes: control register holds master enable, summary flag and sleep state
//
// Overview of operation
// R1: each pin has a rising detector gated by its rise enable bit
// R2: each pin has a falling detector gated by its fall enable bit
// R3: both enables set detects both edge directions on that pin
// R4: an enabled edge sets the pin flag until software clears it
// R5: detection continues with master enable off; only the interrupt is held back
// R6: summary flag reads as the OR of all eight pin flags
// R7: writing zero to a flag bit clears that flag
// R8: an edge during the clearing write leaves the flag set
// R9: software should clear flags by masking only bits known to have changed
// R10: with master enable set, an edge during sleep raises the wake request
// R11: during sleep the flag register updates before the core resumes
// R12: flags set by hardware, read and written by software; zero means no change
// R13: pins sampled twice and compared with the previous sample, one-cycle edge pulse
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pin_change_defines.svh"

module port_pin_change_interrupt #(
  parameter int PIN_COUNT = 8
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire pin_change_pkg::apb_req_s i_apb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  input wire logic [PIN_COUNT-1:0] i_pins,
  input wire logic i_core_asleep,
  output logic o_change_irq,
  output logic o_wake_request,
  output logic o_change_irq_summary_flag
);

  logic [PIN_COUNT-1:0] pin_sync1;
  logic [PIN_COUNT-1:0] pin_sync2;
  logic [PIN_COUNT-1:0] pin_prev;
  logic [PIN_COUNT-1:0] rising_edge_enable;
  logic [PIN_COUNT-1:0] falling_edge_enable;
  logic [PIN_COUNT-1:0] pin_change_flags;
  logic [PIN_COUNT-1:0] next_flags;
  logic [PIN_COUNT-1:0] rise_hit;
  logic [PIN_COUNT-1:0] fall_hit;
  logic [PIN_COUNT-1:0] edge_hit;
  logic change_irq_master_enable;
  logic [31:0] next_prdata;

  wire access = i_apb.psel && i_apb.penable;
  wire wr = access && i_apb.pwrite;
  wire sel_rise = i_apb.paddr == `PCI_OFF_RISE;
  wire sel_fall = i_apb.paddr == `PCI_OFF_FALL;
  wire sel_flags = i_apb.paddr == `PCI_OFF_FLAGS;
  wire sel_ctrl = i_apb.paddr == `PCI_OFF_CTRL;
  wire mapped = sel_rise || sel_fall || sel_flags || sel_ctrl;
  wire wr_flags = wr && sel_flags;
  wire wr_rise = wr && sel_rise;
  wire wr_fall = wr && sel_fall;
  wire wr_ctrl = wr && sel_ctrl;
  wire rd_setup = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
  wire change_irq_summary_flag = |pin_change_flags; // R6

  // pin synchroniser and previous sample
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pin_sync1 <= '0;
      pin_sync2 <= '0;
      pin_prev <= '0;
    end else begin
      pin_sync1 <= i_pins; // R13
      pin_sync2 <= pin_sync1; // R13
      pin_prev <= pin_sync2; // R13
    end
  end

  // per-pin detectors and flag next state
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      assign rise_hit[g] = rising_edge_enable[g] && pin_sync2[g] && !pin_prev[g]; // R1
      assign fall_hit[g] = falling_edge_enable[g] && !pin_sync2[g] && pin_prev[g]; // R2
      assign edge_hit[g] = rise_hit[g] || fall_hit[g]; // R3
      // set wins over the clearing write
      assign next_flags[g] = edge_hit[g] ? 1'b1 : // R4 R8
        (wr_flags ? i_apb.pwdata[g] : pin_change_flags[g]); // R7 R12

      a_pin_rise_flag: assert property (@(posedge i_core_clk) disable iff (i_srst) // R1
        rising_edge_enable[g] && $past(i_pins[g], 2) && !$past(i_pins[g], 3)
        |=> pin_change_flags[g])
        else $error("enabled rise did not set flag");

      a_pin_fall_flag: assert property (@(posedge i_core_clk) disable iff (i_srst) // R2
        falling_edge_enable[g] && !$past(i_pins[g], 2) && $past(i_pins[g], 3)
        |=> pin_change_flags[g])
        else $error("enabled fall did not set flag");

      a_pin_both_edges: assert property (@(posedge i_core_clk) disable iff (i_srst) // R3
        rising_edge_enable[g] && falling_edge_enable[g] &&
        ($past(i_pins[g], 2) != $past(i_pins[g], 3)) |=> pin_change_flags[g])
        else $error("edge missed with both enables set");

      a_pin_flag_sticky: assert property (@(posedge i_core_clk) disable iff (i_srst) // R4
        pin_change_flags[g] && !wr_flags
        |=> pin_change_flags[g])
        else $error("flag dropped without a write");

      a_pin_quiet: assert property (@(posedge i_core_clk) disable iff (i_srst) // R12
        !pin_change_flags[g] && !wr_flags && ($past(i_pins[g], 2) == $past(i_pins[g], 3))
        |=> !pin_change_flags[g])
        else $error("flag set with no change");

      a_pin_write_one: assert property (@(posedge i_core_clk) disable iff (i_srst) // R12
        wr_flags && i_apb.pwdata[g]
        |=> pin_change_flags[g])
        else $error("written one not stored");

      a_pin_zero_clear: assert property (@(posedge i_core_clk) disable iff (i_srst) // R7
        wr_flags && !i_apb.pwdata[g] && ($past(i_pins[g], 2) == $past(i_pins[g], 3))
        |=> !pin_change_flags[g])
        else $error("zero write left flag set");

      a_pin_set_wins: assert property (@(posedge i_core_clk) disable iff (i_srst) // R8
        wr_flags && edge_hit[g]
        |=> pin_change_flags[g])
        else $error("edge lost in clearing write");

      a_pin_pulse_short: assert property (@(posedge i_core_clk) disable iff (i_srst) // R13
        rise_hit[g]
        |=> !rise_hit[g])
        else $error("rise pulse longer than one cycle");

      a_pin_dir_gated: assert property (@(posedge i_core_clk) disable iff (i_srst) // R1
        edge_hit[g] |-> (rising_edge_enable[g] && $past(i_pins[g], 2)) ||
        (falling_edge_enable[g] && !$past(i_pins[g], 2)))
        else $error("edge seen in disabled direction");

      a_pin_sync_stage: assert property (@(posedge i_core_clk) disable iff (i_srst) // R13
        pin_sync2[g]
        == $past(i_pins[g], 2))
        else $error("synchroniser depth wrong");

      a_pin_summary: assert property (@(posedge i_core_clk) disable iff (i_srst) // R6
        pin_change_flags[g]
        |-> o_change_irq_summary_flag)
        else $error("summary misses a flag");

      a_pin_irq: assert property (@(posedge i_core_clk) disable iff (i_srst) // R5
        pin_change_flags[g] && change_irq_master_enable
        |-> o_change_irq)
        else $error("enabled flag gave no interrupt");
    end
  endgenerate

  always_comb begin
    next_prdata = '0;
    if (sel_rise) begin
      next_prdata[PIN_COUNT-1:0] = rising_edge_enable;
    end else if (sel_fall) begin
      next_prdata[PIN_COUNT-1:0] = falling_edge_enable;
    end else if (sel_flags) begin
      next_prdata[PIN_COUNT-1:0] = pin_change_flags; // R12
    end else if (sel_ctrl) begin
      next_prdata[`PCI_CTRL_MASTER_BIT] = change_irq_master_enable;
      next_prdata[`PCI_CTRL_SUMMARY_BIT] = change_irq_summary_flag; // R6
      next_prdata[`PCI_CTRL_SLEEP_BIT] = i_core_asleep;
    end
  end

  // enable registers, written only by software
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rising_edge_enable <= `PCI_RST_RISE;
    end else if (wr_rise) begin
      rising_edge_enable <= i_apb.pwdata[PIN_COUNT-1:0]; // R1
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      falling_edge_enable <= `PCI_RST_FALL;
    end else if (wr_fall) begin
      falling_edge_enable <= i_apb.pwdata[PIN_COUNT-1:0]; // R2
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      change_irq_master_enable <= 1'b0;
    end else if (wr_ctrl) begin
      change_irq_master_enable <= i_apb.pwdata[`PCI_CTRL_MASTER_BIT]; // R5
    end
  end

  // flags update every cycle, awake or asleep
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pin_change_flags <= `PCI_RST_FLAGS;
    end else begin
      pin_change_flags <= next_flags; // R4 R5 R11
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_prdata <= '0;
    end else if (rd_setup) begin
      o_prdata <= next_prdata;
    end
  end

  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;
  assign o_change_irq_summary_flag = change_irq_summary_flag; // R6
  assign o_change_irq = change_irq_master_enable && change_irq_summary_flag; // R5
  assign o_wake_request = o_change_irq && i_core_asleep; // R10

  a_flag_sets_on_edge: assert property (@(posedge i_core_clk) disable iff (i_srst) // R4
    edge_hit != '0 |=> (pin_change_flags & $past(edge_hit)) == $past(edge_hit))
    else $error("enabled edge did not set its flag");

  a_set_beats_clear: assert property (@(posedge i_core_clk) disable iff (i_srst) // R8
    wr_flags && edge_hit[0] |=> pin_change_flags[0])
    else $error("edge lost during clearing write");

  a_zero_write_clears: assert property (@(posedge i_core_clk) disable iff (i_srst) // R7
    wr_flags && !i_apb.pwdata[0] && !edge_hit[0] |=> !pin_change_flags[0])
    else $error("zero write did not clear flag");

  a_rise_detect_gated: assert property (@(posedge i_core_clk) disable iff (i_srst) // R1
    ##1 $rose(pin_sync2[1]) && rising_edge_enable[1] |-> edge_hit[1])
    else $error("rising edge missed");

  a_fall_detect_gated: assert property (@(posedge i_core_clk) disable iff (i_srst) // R2
    edge_hit[2] |-> (rising_edge_enable[2] && pin_sync2[2]) ||
      (falling_edge_enable[2] && !pin_sync2[2]))
    else $error("edge seen without matching enable");

  a_sync_latency: assert property (@(posedge i_core_clk) disable iff (i_srst) // R13
    ##3 rising_edge_enable[3] && $past(i_pins[3], 2) && !$past(i_pins[3], 3) |-> edge_hit[3])
    else $error("edge not flagged two cycles after pin change");

  a_edge_one_cycle: assert property (@(posedge i_core_clk) disable iff (i_srst) // R13
    fall_hit[4] |=> !fall_hit[4])
    else $error("edge pulse malformed");

  a_summary_is_or: assert property (@(posedge i_core_clk) disable iff (i_srst) // R6
    o_change_irq_summary_flag == (pin_change_flags != '0))
    else $error("summary flag mismatch");

  a_irq_masked: assert property (@(posedge i_core_clk) disable iff (i_srst) // R5
    !change_irq_master_enable && edge_hit != '0 |=> !o_change_irq && pin_change_flags != '0)
    else $error("master enable gating wrong");

  a_wake_on_edge: assert property (@(posedge i_core_clk) disable iff (i_srst) // R10
    change_irq_master_enable && i_core_asleep && edge_hit != '0 && !wr_flags
      ##1 i_core_asleep && change_irq_master_enable |-> o_wake_request)
    else $error("no wake on edge in sleep");

  a_flags_before_wake: assert property (@(posedge i_core_clk) disable iff (i_srst) // R11
    o_wake_request |-> pin_change_flags != '0)
    else $error("wake without updated flags");

  a_rise_enable_write: assert property (@(posedge i_core_clk) disable iff (i_srst) // R1
    wr_rise
    |=> rising_edge_enable == $past(i_apb.pwdata[PIN_COUNT-1:0]))
    else $error("rise enable write lost");

  a_fall_enable_write: assert property (@(posedge i_core_clk) disable iff (i_srst) // R2
    wr_fall
    |=> falling_edge_enable == $past(i_apb.pwdata[PIN_COUNT-1:0]))
    else $error("fall enable write lost");

  a_master_write: assert property (@(posedge i_core_clk) disable iff (i_srst) // R5
    wr_ctrl
    |=> change_irq_master_enable == $past(i_apb.pwdata[`PCI_CTRL_MASTER_BIT]))
    else $error("master enable write lost");

  a_rise_enable_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // R1
    !wr_rise
    |=> $stable(rising_edge_enable))
    else $error("rise enables changed without write");

  a_fall_enable_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // R2
    !wr_fall
    |=> $stable(falling_edge_enable))
    else $error("fall enables changed without write");

  a_master_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // R5
    !wr_ctrl
    |=> $stable(change_irq_master_enable))
    else $error("master enable changed without write");

  a_irq_follows: assert property (@(posedge i_core_clk) disable iff (i_srst) // R5
    o_change_irq ==
    (change_irq_master_enable && (pin_change_flags != '0)))
    else $error("interrupt not master and summary");

  a_wake_needs_sleep: assert property (@(posedge i_core_clk) disable iff (i_srst) // R10
    o_wake_request
    |-> i_core_asleep && change_irq_master_enable)
    else $error("wake request while awake or masked");

  a_wake_in_sleep: assert property (@(posedge i_core_clk) disable iff (i_srst) // R10
    i_core_asleep && o_change_irq
    |-> o_wake_request)
    else $error("interrupt in sleep gave no wake");

  a_sleep_flag_update: assert property (@(posedge i_core_clk) disable iff (i_srst) // R11
    i_core_asleep && edge_hit != '0
    |=> (pin_change_flags & $past(edge_hit)) == $past(edge_hit))
    else $error("flag not updated in sleep");

  a_flags_read: assert property (@(posedge i_core_clk) disable iff (i_srst) // R12
    rd_setup && sel_flags
    |=> o_prdata[PIN_COUNT-1:0] == $past(pin_change_flags))
    else $error("flag read wrong");

  a_read_upper_zero: assert property (@(posedge i_core_clk) disable iff (i_srst) // R12
    rd_setup
    |=> o_prdata[31:PIN_COUNT] == '0)
    else $error("unused read bits not zero");

  a_ctrl_summary_read: assert property (@(posedge i_core_clk) disable iff (i_srst) // R6
    rd_setup && sel_ctrl
    |=> o_prdata[`PCI_CTRL_SUMMARY_BIT] == $past(change_irq_summary_flag))
    else $error("summary read wrong");

  a_ctrl_sleep_read: assert property (@(posedge i_core_clk) disable iff (i_srst) // R10
    rd_setup && sel_ctrl
    |=> o_prdata[`PCI_CTRL_SLEEP_BIT] == $past(i_core_asleep))
    else $error("sleep state read wrong");

  a_ctrl_master_read: assert property (@(posedge i_core_clk) disable iff (i_srst) // R5
    rd_setup && sel_ctrl
    |=> o_prdata[`PCI_CTRL_MASTER_BIT] == $past(change_irq_master_enable))
    else $error("master enable read wrong");

  a_rise_read: assert property (@(posedge i_core_clk) disable iff (i_srst) // R1
    rd_setup && sel_rise
    |=> o_prdata[PIN_COUNT-1:0] == $past(rising_edge_enable))
    else $error("rise enable read wrong");

  a_fall_read: assert property (@(posedge i_core_clk) disable iff (i_srst) // R2
    rd_setup && sel_fall
    |=> o_prdata[PIN_COUNT-1:0] == $past(falling_edge_enable))
    else $error("fall enable read wrong");

  a_prdata_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // R12
    !rd_setup
    |=> $stable(o_prdata))
    else $error("read data changed outside read setup");

  a_unmapped_ignored: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wr && !mapped
    |=> $stable(rising_edge_enable) && $stable(falling_edge_enable))
    else $error("unmapped write changed a register");

endmodule : port_pin_change_interrupt

/* File: bench/pin_driver.sv */
// Purpose: far side model, the levels on the port pins
// Assumes: the bench changes a level just after a clock edge
// Notes: each level stands at least one cycle
`timescale 1ns/1ps
module pin_driver (
  input wire logic [7:0] i_level,
  output logic [7:0] o_pins
);
  assign o_pins = i_level;
endmodule : pin_driver

/* File: bench/test_port_pin_change_interrupt.sv */
// Purpose: self-checking bench of the pin change block
// Assumes: zero wait apb slave, pins taken on i_core_clk
// Notes: one task per scenario, called in sequence
`timescale 1ns/1ps
`include "pin_change_defines.svh"
module test_port_pin_change_interrupt;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic asleep = 1'b0;
  logic pready, perr, pslverr, irq, wake, summ;
  logic [31:0] prdata, rd;
  logic [7:0] level = 8'h00;
  logic [7:0] pins;
  pin_change_pkg::apb_req_s req = '0;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  pin_driver pin_driver_i (.i_level(level), .o_pins(pins));
  port_pin_change_interrupt port_pin_change_interrupt_i (.i_core_clk(clk), .i_srst(srst),
    .i_apb(req), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_pins(pins),
    .i_core_asleep(asleep), .o_change_irq(irq), .o_wake_request(wake),
    .o_change_irq_summary_flag(summ));
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    req <= '0;
  endtask : apb
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic pins_to(input logic [7:0] v);
    @(posedge clk);
    level <= v;
    repeat (3) @(posedge clk);
  endtask : pins_to
  task automatic outs(input logic [2:0] e);
    @(negedge clk);
    chk({29'h0, irq, wake, summ}, {29'h0, e});
  endtask : outs
  task automatic s_regs;
    rdchk(`PCI_OFF_FLAGS, 32'h0);
    rdchk(`PCI_OFF_FALL, 32'h0);
    apb(1'b1, 4'h2, 32'hff);
    chk({31'h0, perr}, 32'h1);
    apb(1'b1, `PCI_OFF_RISE, 32'h0f);
    apb(1'b1, `PCI_OFF_FALL, 32'h3c);
    rdchk(`PCI_OFF_RISE, 32'h0f);
  endtask : s_regs
  task automatic s_edges;
    pins_to(8'hff);
    rdchk(`PCI_OFF_FLAGS, 32'h0f);
    outs(3'b001);
    apb(1'b1, `PCI_OFF_FLAGS, 32'h0);
    rdchk(`PCI_OFF_FLAGS, 32'h0);
    outs(3'b000);
    pins_to(8'h00);
    rdchk(`PCI_OFF_FLAGS, 32'h3c);
  endtask : s_edges
  task automatic s_race;
    @(posedge clk);
    level <= 8'h01;
    apb(1'b1, `PCI_OFF_FLAGS, 32'h0);
    rdchk(`PCI_OFF_FLAGS, 32'h01);
  endtask : s_race
  task automatic s_wake;
    apb(1'b1, `PCI_OFF_FLAGS, 32'h0);
    apb(1'b1, `PCI_OFF_CTRL, 32'h1);
    @(posedge clk);
    asleep <= 1'b1;
    pins_to(8'h10);
    outs(3'b000);
    pins_to(8'h00);
    outs(3'b111);
    rdchk(`PCI_OFF_FLAGS, 32'h10);
    rdchk(`PCI_OFF_CTRL, 32'h7);
    apb(1'b1, `PCI_OFF_CTRL, 32'h0);
    outs(3'b001);
  endtask : s_wake
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    s_regs();
    s_edges();
    s_race();
    s_wake();
    close_out();
  end
endmodule : test_port_pin_change_interrupt
